// ==== edge_timer_pkg.sv ====
// package: register map, field positions, reset values and timing counts for the edge timer
package edge_timer_pkg;

  // ************************************************************
  // register byte offsets (one aligned word each)
  // ************************************************************
  localparam logic [7:0] OFF_MODE_CONTROL = 8'h00;
  localparam logic [7:0] OFF_FALL_CAPTURE = 8'h04;
  localparam logic [7:0] OFF_RISE_CAPTURE = 8'h08;
  localparam logic [7:0] OFF_CLOCK_STOP = 8'h0C;
  localparam logic [7:0] OFF_PORT_MODE = 8'h10;

  // ************************************************************
  // timer_mode_control field positions
  // ************************************************************
  localparam int BIT_OVF_HIGH = 7;
  localparam int BIT_OVF_LOW = 6;
  localparam int BIT_OVF_IRQ_EN = 5;
  localparam int BIT_IRQ_EDGE = 4;
  localparam int BIT_CLEAR_HI = 3;
  localparam int BIT_CLEAR_LO = 2;
  localparam int BIT_CLOCK_HI = 1;
  localparam int BIT_CLOCK_LO = 0;

  // module_clock_stop: timer run bit
  localparam int BIT_TIMER_RUN = 3;
  // port mode: capture pin select and filter select
  localparam int BIT_CAPTURE_PIN = 0;
  localparam int BIT_FILTER_SEL = 1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_CAPTURE = 8'h00;
  localparam logic [7:0] RST_CLOCK_STOP = 8'hFF;
  localparam logic [7:0] RST_PORT_MODE = 8'h00;
  localparam logic [7:0] RST_COUNTER = 8'h00;

  // ************************************************************
  // timing: prescaler divides and filter length
  // ************************************************************
  localparam int DIV_SYS_64 = 64;
  localparam int DIV_SYS_32 = 32;
  localparam int DIV_SYS_2 = 2;
  localparam int DIV_WATCH_4 = 4;
  localparam int FILTER_STAGES = 5;

  // clock select encodings
  typedef enum logic [1:0] {CLK_DIV64, CLK_DIV32, CLK_DIV2, CLK_WATCH4} clock_sel_t;

endpackage : edge_timer_pkg

// ==== noise_filter.sv ====
// noise filter: five serial sampling latches with an all-agree match detector
`timescale 1ns/1ps
module noise_filter #(
  parameter int STAGES = 5
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sampling strobe and data
  input wire logic sample_en,
  input wire logic din,
  // filtered level
  output logic dout
);

  // shift chain; reset low so the output stays low until five high samples
  logic [STAGES-1:0] chain_reg;

  // ************************************************************
  // sample chain
  // ************************************************************
  // shift on the selected sampling strobe only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chain_reg <= '0;
    else if (sample_en)
      chain_reg <= {chain_reg[STAGES-2:0], din};
  end

  // ************************************************************
  // match detector
  // ************************************************************
  // output moves only when every latch agrees, else it holds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dout <= 1'b0;
    else if (&chain_reg)
      dout <= 1'b1;
    else if (~|chain_reg)
      dout <= 1'b0;
  end

endmodule : noise_filter

// ==== edge_capture_timer.sv ====
// edge capture timer: apb registers, prescaler, up counter, edge capture and overflow flags
`timescale 1ns/1ps
module edge_capture_timer
  import edge_timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // apb answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture pin and watch clock strobe
  input wire logic capture_pin,
  input wire logic watch_tick,
  // interrupt enable from the cpu side and request out
  input wire logic timer_irq_enable,
  output logic timer_irq_request_flag
);

  import edge_timer_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0] timer_mode_control_reg; // mode control with flags
  logic [7:0] module_clock_stop_reg; // per-module run bits
  logic [7:0] port_mode_reg; // capture pin and filter select
  logic [WIDTH-1:0] falling_edge_capture_reg; // falling capture value
  logic [WIDTH-1:0] rising_edge_capture_reg; // rising capture value
  logic [WIDTH-1:0] up_counter_reg; // hidden counter
  logic [5:0] prescale_reg; // system clock divider
  logic [1:0] watch_div_reg; // watch tick divider
  logic tick; // selected count strobe
  logic sample_en; // filter sampling strobe
  logic filtered; // filter output
  logic level_reg; // last accepted capture level
  logic cur_level; // level entering the edge detector
  logic rise_evt; // detected rising edge
  logic fall_evt; // detected falling edge
  logic wrap_evt; // counter wraps to zero
  logic running; // module out of standby
  logic capture_mode; // capture versus interval
  logic filter_on; // filter selected
  logic wr_en; // apb write access
  logic [1:0] clear_sel; // clear edge field
  clock_sel_t clk_sel; // clock source field
  logic irq_reg; // irq request flag register

  assign running = module_clock_stop_reg[BIT_TIMER_RUN];
  assign capture_mode = port_mode_reg[BIT_CAPTURE_PIN];
  assign filter_on = port_mode_reg[BIT_FILTER_SEL];
  assign clear_sel = timer_mode_control_reg[BIT_CLEAR_HI:BIT_CLEAR_LO];
  assign clk_sel = clock_sel_t'(timer_mode_control_reg[BIT_CLOCK_HI:BIT_CLOCK_LO]);
  assign wr_en = psel && penable && pwrite;

  // divider strobe helper: true when the low bits of a counter are all ones
  function automatic logic div_hit(input logic [5:0] cnt, input int div);
    logic [5:0] mask;
    mask = 6'(div - 1);
    return (cnt & mask) == mask;
  endfunction : div_hit

  // ************************************************************
  // prescaler and clock select
  // ************************************************************
  // free running divider; standby halts it so nothing counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prescale_reg <= 6'h00;
    else if (running)
      prescale_reg <= prescale_reg + 6'h01;
  end

  // watch ticks are assumed already synchronous one-cycle strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watch_div_reg <= 2'h0;
    else if (running && watch_tick)
      watch_div_reg <= watch_div_reg + 2'h1;
  end

  // pick the increment source
  always_comb
  begin
    tick = 1'b0;
    unique case (clk_sel)
      CLK_DIV64: tick = div_hit(prescale_reg, DIV_SYS_64);
      CLK_DIV32: tick = div_hit(prescale_reg, DIV_SYS_32);
      CLK_DIV2: tick = div_hit(prescale_reg, DIV_SYS_2);
      CLK_WATCH4: tick = watch_tick && (watch_div_reg == 2'(DIV_WATCH_4 - 1));
    endcase
    tick = tick && running;
  end

  // system clock when filter off, counter clock when on
  assign sample_en = running && (filter_on ? tick : 1'b1);

  // ************************************************************
  // noise filter and edge detection
  // ************************************************************
  noise_filter #(
    .STAGES(FILTER_STAGES)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .sample_en(sample_en),
    .din(capture_pin),
    .dout(filtered)
  );

  // bypass takes the raw pin; the source must then hold levels one clock
  assign cur_level = filter_on ? filtered : capture_pin;

  // last level; switching filter select may show as an edge, accepted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_reg <= 1'b0;
    else if (running)
      level_reg <= cur_level;
  end

  // edges only count in capture mode and out of standby
  assign rise_evt = running && capture_mode && cur_level && !level_reg;
  assign fall_evt = running && capture_mode && !cur_level && level_reg;
  assign wrap_evt = tick && (up_counter_reg == {WIDTH{1'b1}});

  // ************************************************************
  // counter
  // ************************************************************
  // count up, clearing on the chosen edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_counter_reg <= RST_COUNTER;
    else if ((fall_evt && clear_sel[0]) || (rise_evt && clear_sel[1]))
      up_counter_reg <= RST_COUNTER;
    else if (tick)
      up_counter_reg <= up_counter_reg + 1'b1;
  end

  // ************************************************************
  // capture registers
  // ************************************************************
  // the old counter value is taken before any clear lands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      falling_edge_capture_reg <= RST_CAPTURE;
    else if (fall_evt)
      falling_edge_capture_reg <= up_counter_reg;
  end

  // rising edge copy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rising_edge_capture_reg <= RST_CAPTURE;
    else if (rise_evt)
      rising_edge_capture_reg <= up_counter_reg;
  end

  // ************************************************************
  // mode control register and overflow flags
  // ************************************************************
  // flags: writing one does nothing, zero clears, a fresh set beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_mode_control_reg <= RST_MODE_CONTROL;
    else
    begin
      if (wr_en && paddr == OFF_MODE_CONTROL)
      begin
        timer_mode_control_reg[5:0] <= pwdata[5:0];
        if (!pwdata[BIT_OVF_HIGH])
          timer_mode_control_reg[BIT_OVF_HIGH] <= 1'b0;
        if (!pwdata[BIT_OVF_LOW])
          timer_mode_control_reg[BIT_OVF_LOW] <= 1'b0;
      end
      if (wrap_evt && capture_mode && cur_level)
        timer_mode_control_reg[BIT_OVF_HIGH] <= 1'b1;
      if (wrap_evt && (!capture_mode || !cur_level))
        timer_mode_control_reg[BIT_OVF_LOW] <= 1'b1;
    end
  end

  // ************************************************************
  // clock stop and port mode registers
  // ************************************************************
  // all bits stored; only the timer run bit steers this block
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      module_clock_stop_reg <= RST_CLOCK_STOP;
    else if (wr_en && paddr == OFF_CLOCK_STOP)
      module_clock_stop_reg <= pwdata[7:0];
  end

  // capture pin select and filter select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_mode_reg <= RST_PORT_MODE;
    else if (wr_en && paddr == OFF_PORT_MODE)
      port_mode_reg <= {6'h00, pwdata[1:0]};
  end

  // ************************************************************
  // interrupt request flag
  // ************************************************************
  // sets on the chosen capture edge or enabled overflow, but only while the
  // cpu-side enable is high, and clears on the next clock as a one-cycle pulse,
  // since the request register itself lives outside this block
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= timer_irq_enable &&
        ((timer_mode_control_reg[BIT_IRQ_EDGE] ? fall_evt : rise_evt) ||
         (wrap_evt && timer_mode_control_reg[BIT_OVF_IRQ_EN]));
  end

  assign timer_irq_request_flag = irq_reg;

  // ************************************************************
  // apb slave
  // ************************************************************
  // zero wait states: pready is a registered copy of the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  // unmapped addresses answer with an error and zero data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (psel && !penable)
      pslverr <= !(paddr == OFF_MODE_CONTROL || paddr == OFF_FALL_CAPTURE ||
                   paddr == OFF_RISE_CAPTURE || paddr == OFF_CLOCK_STOP ||
                   paddr == OFF_PORT_MODE);
    else
      pslverr <= 1'b0;
  end

  // read data latched in setup, stable through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        OFF_MODE_CONTROL: prdata <= {24'h000000, timer_mode_control_reg};
        OFF_FALL_CAPTURE: prdata <= {24'h000000, falling_edge_capture_reg};
        OFF_RISE_CAPTURE: prdata <= {24'h000000, rising_edge_capture_reg};
        OFF_CLOCK_STOP: prdata <= {24'h000000, module_clock_stop_reg};
        OFF_PORT_MODE: prdata <= {24'h000000, port_mode_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule : edge_capture_timer

// ==== edge_timer_checker.sv ====
// checker: apb answer and irq relations watched at the timer ports
`timescale 1ns/1ps
module edge_timer_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request and answer
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin and interrupt
  input wire logic capture_pin,
  input wire logic watch_tick,
  input wire logic timer_irq_enable,
  input wire logic timer_irq_request_flag
);
  import edge_timer_pkg::*;
  // ************************************************************
  // port relations
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero wait states: the access phase always gets its answer
  answer_next_a: assert property (psel && !penable |=> pready && penable)
    else $error("no answer in access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (pready && !pwrite && paddr >= 8'h14 |-> pslverr && prdata == 0)
    else $error("unmapped read not refused");
  mapped_ok_a: assert property (
    pready && paddr <= OFF_PORT_MODE && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // read data only moves on a read setup
  rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  irq_gate_a: assert property (
    !timer_irq_enable && !$past(timer_irq_enable) |-> !timer_irq_request_flag)
    else $error("request while disabled");
  // control bits written to mode control read back on a read set up two cycles after the write answer
  mode_rw_a: assert property (
    pready && pwrite && paddr == OFF_MODE_CONTROL ##2
    psel && !penable && !pwrite && paddr == OFF_MODE_CONTROL
    |=> prdata[5:0] == $past(pwdata[5:0], 3))
    else $error("mode bits not kept");
  // outputs are unknown until the first clock edge under reset, so look from the second
  reset_quiet_a: assert property (
    disable iff (1'b0) !presetn ##1 !presetn |-> !pready && !timer_irq_request_flag && prdata == 0)
    else $error("outputs active in reset");
  cover property (pslverr);
  cover property (timer_irq_request_flag);
  cover property (pready && pwrite && paddr == OFF_MODE_CONTROL);
endmodule : edge_timer_checker
bind edge_capture_timer edge_timer_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin), .watch_tick(watch_tick),
  .timer_irq_enable(timer_irq_enable), .timer_irq_request_flag(timer_irq_request_flag));

// ==== pulse_source.sv ====
// partner: pulse source driving the capture pin
`timescale 1ns/1ps
module pulse_source (
  // clock and command
  input wire logic pclk,
  input wire logic go,
  input wire logic idle_lvl,
  input wire logic [7:0] lo_cyc,
  input wire logic [7:0] hi_cyc,
  // pin and status
  output logic pin,
  output logic busy
);
  // ************************************************************
  // pulse sequencer
  // ************************************************************
  logic [8:0] cnt_reg; // cycles into the pulse
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // low, then high, then one clock low, then idle level; each level lasts whole clocks
  always @(posedge pclk)
  begin
    if (go && !busy)
    begin
      busy <= 1'b1;
      cnt_reg <= 9'h000;
      pin <= 1'b0;
    end
    else if (busy)
    begin
      cnt_reg <= cnt_reg + 9'h001;
      if (cnt_reg + 9'h001 == {1'b0, lo_cyc})
        pin <= 1'b1;
      if (cnt_reg + 9'h001 == {1'b0, lo_cyc} + {1'b0, hi_cyc})
      begin
        pin <= 1'b0;
        busy <= 1'b0;
      end
    end
    else
      pin <= idle_lvl; // static level for overflow runs
  end
endmodule : pulse_source

// ==== edge_capture_timer_with_noise_filter_tb_top.sv ====
// testbench: registers, capture, overflow, standby and filter scenarios
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
$display("Error at %0t: got %0h want %0h", $time, (a), (b)); end end
module edge_capture_timer_with_noise_filter_tb_top;
  import edge_timer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic capture_pin;
  logic watch_tick = 1'b0;
  logic timer_irq_enable = 1'b0;
  logic timer_irq_request_flag;
  logic go = 1'b0;
  logic idle_lvl = 1'b0;
  logic [7:0] lo_cyc = 8'h00;
  logic [7:0] hi_cyc = 8'h00;
  logic busy;
  int err_total = 0;
  int n_checks = 0;
  int irq_cnt = 0;
  logic [33:0] q_exp[$]; // {loose, pslverr, prdata}; loose allows two counts of slack
  logic [33:0] e;
  logic [7:0] r_exp[3] = '{8'h1F, 8'h33, 8'h1F}; // rising capture for clear modes 1..3
  logic [7:0] f_exp[3] = '{8'h33, 8'h14, 8'h14}; // falling capture for clear modes 1..3
  edge_capture_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_pin(capture_pin), .watch_tick(watch_tick),
    .timer_irq_enable(timer_irq_enable), .timer_irq_request_flag(timer_irq_request_flag));
  pulse_source u_src (.pclk(pclk), .go(go), .idle_lvl(idle_lvl), .lo_cyc(lo_cyc),
    .hi_cyc(hi_cyc), .pin(capture_pin), .busy(busy));
  // ************************************************************
  // clock, watch strobe and answer monitor
  // ************************************************************
  always #2 pclk = ~pclk;
  always @(posedge pclk) watch_tick <= ($urandom % 4) == 0;
  // counts irq pulses and checks each read answer against the oldest note
  always @(posedge pclk)
  begin
    if (timer_irq_request_flag === 1'b1)
      irq_cnt++;
    if (psel && penable && pready === 1'b1 && !pwrite && q_exp.size() > 0)
    begin
      e = q_exp.pop_front();
      `CHK(pslverr, e[32])
      `CHK($isunknown(prdata), 1'b0)
      `CHK(e[33] ? 8'(prdata[7:0] - e[7:0] + 8'h02) <= 8'h04 : prdata == e[31:0], 1'b1)
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // one apb transfer; waits for pready under a bound, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is looked at on the rising edge itself, before that edge updates it
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 20)
    begin
      err_total++;
      results();
    end
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] ex);
    q_exp.push_back(ex);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // waits on a settled level, then resumes on a rising edge
  task automatic wait_for(input int which, input int lim);
    int n;
    n = 0;
    @(negedge pclk);
    while ((which == 0 ? busy === 1'b1 : timer_irq_request_flag !== 1'b1) && n < lim)
    begin
      n++;
      @(negedge pclk);
    end
    if (n == lim)
    begin
      err_total++;
      results();
    end
    @(posedge pclk);
  endtask : wait_for
  task automatic pulse(input logic [7:0] lo, input logic [7:0] hi);
    lo_cyc <= lo;
    hi_cyc <= hi;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    wait_for(0, 600);
  endtask : pulse
  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    void'($urandom(32'hA811));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_MODE_CONTROL, 34'h0);
    rd(OFF_FALL_CAPTURE, 34'h0);
    rd(OFF_CLOCK_STOP, 34'hFF);
    wr(OFF_RISE_CAPTURE, 32'hFF);
    rd(OFF_RISE_CAPTURE, 34'h0);
    rd(8'h14, 34'h1_0000_0000);
    wr(OFF_PORT_MODE, 32'h1);
    timer_irq_enable <= 1'b1;
    // each clear mode with one irq edge, falling for modes 1 and 3, rising for 2; capture keeps the pre-clear count
    for (int m = 1; m < 4; m++)
    begin
      wr(OFF_MODE_CONTROL, (32'(m) << 2) | (32'(m % 2) << 4) | 32'h2);
      irq_cnt = 0;
      pulse(8'h3C, 8'h28);
      pulse(8'h3C, 8'h28);
      rd(OFF_RISE_CAPTURE, {2'b10, 24'h0, r_exp[m - 1]});
      rd(OFF_FALL_CAPTURE, {2'b10, 24'h0, f_exp[m - 1]});
      `CHK(irq_cnt, 2)
    end
    timer_irq_enable <= 1'b0;
    irq_cnt = 0;
    pulse(8'h3C, 8'h28);
    `CHK(irq_cnt, 0)
    // overflow flags: high level, write-one ignored, zero clears, low level
    idle_lvl <= 1'b1;
    wr(OFF_MODE_CONTROL, 32'h22);
    timer_irq_enable <= 1'b1;
    wait_for(1, 1100);
    rd(OFF_MODE_CONTROL, 34'hA2);
    wr(OFF_MODE_CONTROL, 32'hE2);
    rd(OFF_MODE_CONTROL, 34'hA2);
    wr(OFF_MODE_CONTROL, 32'h22);
    rd(OFF_MODE_CONTROL, 34'h22);
    idle_lvl <= 1'b0;
    wait_for(1, 1100);
    rd(OFF_MODE_CONTROL, 34'h62);
    // interval mode: a high pin still sets the low flag
    wr(OFF_PORT_MODE, 32'h0);
    wr(OFF_MODE_CONTROL, 32'h22);
    idle_lvl <= 1'b1;
    wait_for(1, 1100);
    rd(OFF_MODE_CONTROL, 34'h62);
    // standby halts counting longer than one full wrap
    wr(OFF_CLOCK_STOP, 32'hF7);
    rd(OFF_CLOCK_STOP, 34'hF7);
    wr(OFF_MODE_CONTROL, 32'h22);
    irq_cnt = 0;
    repeat (600) @(posedge pclk);
    rd(OFF_MODE_CONTROL, 34'h22);
    `CHK(irq_cnt, 0)
    wr(OFF_CLOCK_STOP, 32'hFF);
    // filter on the /2 strobe: three-sample pulse dropped, long pulse kept
    idle_lvl <= 1'b0;
    wr(OFF_PORT_MODE, 32'h3);
    wr(OFF_MODE_CONTROL, 32'h02);
    repeat (20) @(posedge pclk); // a switch may fake one capture
    irq_cnt = 0;
    pulse(8'h3C, 8'h06);
    `CHK(irq_cnt, 0)
    pulse(8'h3C, 8'h28);
    `CHK(irq_cnt, 1)
    // slower count sources, filter off: a 200-cycle high pulse on /32 then /64
    wr(OFF_PORT_MODE, 32'h1);
    for (int c = 0; c < 2; c++)
    begin
      wr(OFF_MODE_CONTROL, 32'h0D - 32'(c));
      pulse(8'h3C, 8'hC8);
      rd(OFF_FALL_CAPTURE, {2'b10, 24'h0, 8'h07 >> c});
    end
    results();
  end
endmodule : edge_capture_timer_with_noise_filter_tb_top
